// ---- hdl/dbom_mapper.sv ----
// Purpose: host decode, buffer placement and overlay composition
// Assumes: one host access per enabled cycle; pixel stream in display order
// Notes:   pixel colour paths use 16-bit 5-6-5 values after colour lookup
//
// Overview of operation
// - select zero puts overlay at size minus 1K
// - select n puts overlay at size minus 8K*n
// - overlay stride: line width+1 ink, 8 cursor
// - zero modulation select picks default shading
// - register access indexed by six address bits
// - memory access uses 21-bit host address
// - 2M space decoded, 512K aliased throughout
// - half-frame buffer sits at buffer top
// - half-frame size width*height*factor/16
// - 16-bit line width gives line stride
// - screen starts from three byte registers each
// - pan low nibble screen 1, high screen 2
// - screen 1 through last line, then screen 2
// - monochrome modes use green table only
// - 15/16 bpp bypass colour tables
// - only selected overlay buffer is rendered
// - overlay data is two bits per pixel
// - codes: colour0, colour1, background, inverted
// - ink overlay covers whole display
// - cursor is 64x64 at programmed position
// - cursor coordinates are never negative
// - mode 00 off, 01 cursor, 10 ink
// - overlay colours are 16-bit 5-6-5
// - cursor coordinates are ten bits
`timescale 1ns/100ps
module dbom_mapper
  import dbom_pkg::*;
(
  input  wire logic           sys_clk,
  input  wire logic           rst,
  input  wire logic           clk_en,
  input  wire dbom_host_req_t host_req,
  output logic [7:0]          reg_rdata,
  output logic                reg_rvalid,
  output dbom_mem_req_t       mem_req,
  input  wire logic           buf_is_2m,
  input  wire logic           dual_panel,
  input  wire logic           hfb_enable,
  input  wire logic           colour_panel,
  input  wire logic           mono_mode,
  input  wire logic           direct_colour,
  input  wire logic [9:0]     panel_width,
  input  wire logic [9:0]     panel_height,
  input  wire logic [9:0]     line_count,
  input  wire dbom_pixel_t    pixel_in,
  input  wire logic [3:0]     lut_red,
  input  wire logic [3:0]     lut_green,
  input  wire logic [3:0]     lut_blue,
  output dbom_pixel_t         pixel_out,
  output logic [20:0]         ovl_start_addr,
  output logic [15:0]         ovl_line_words,
  output logic [20:0]         hfb_start_addr,
  output logic [20:0]         hfb_size,
  output logic [15:0]         image_line_words,
  output logic [19:0]         scr1_start_word,
  output logic [19:0]         scr2_start_word,
  output logic [3:0]          scr1_pan,
  output logic [3:0]          scr2_pan,
  output logic                screen2_active,
  output logic                gray_mod_alt
);

  logic [7:0] regs_reg  [0:63];
  logic [7:0] regs_next [0:63];
  logic [7:0]     reg_rdata_next;
  logic           reg_rvalid_next;
  dbom_mem_req_t  mem_req_next;
  dbom_pixel_t    pixel_next;
  logic [21:0]    buf_size;
  logic [21:0]    ovl_addr_full;
  logic [21:0]    hfb_full;
  dbom_ovl_mode_t ovl_mode;
  logic [9:0]     cur_x;
  logic [9:0]     cur_y;
  logic [15:0]    col0;
  logic [15:0]    col1;
  logic [15:0]    back_colour;
  logic [15:0]    last_line;
  logic           in_cursor;

  function automatic logic [15:0] pair16(input logic [7:0] hi, input logic [7:0] lo);
    pair16 = {hi, lo};
  endfunction : pair16

  function automatic logic [15:0] mask_bits(input logic [7:0] lo, input logic [7:0] hi);
    mask_bits = {6'h00, hi[CUR_HI_BITS-1:0], lo};
  endfunction : mask_bits

  function automatic logic [15:0] expand_444(input logic [3:0] r, input logic [3:0] g,
                                             input logic [3:0] b);
    expand_444 = {r, r[3], g, g[3:2], b, b[3]};
  endfunction : expand_444

  // register port and memory decode
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      regs_next[i] = regs_reg[i];
    end
    reg_rdata_next  = reg_rdata;
    reg_rvalid_next = 1'b0;
    mem_req_next    = '0;
    if (!host_req.cs_n && !host_req.mem_sel) begin
      if (host_req.wr) begin
        regs_next[host_req.addr[5:0]] = host_req.wdata;
      end
      if (host_req.rd) begin
        reg_rdata_next  = regs_reg[host_req.addr[5:0]];
        reg_rvalid_next = 1'b1;
      end
    end
    if (!host_req.cs_n && host_req.mem_sel) begin
      mem_req_next.mem_sel = 1'b1;
      mem_req_next.rd      = host_req.rd;
      mem_req_next.wr      = host_req.wr;
      mem_req_next.wdata   = host_req.wdata;
      mem_req_next.addr    = host_req.addr & (buf_is_2m ? BUF_MASK_2M : BUF_MASK_512K);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < 64; i++) begin
        regs_reg[i] <= RESET_BYTE;
      end
      reg_rdata  <= RESET_BYTE;
      reg_rvalid <= 1'b0;
      mem_req    <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < 64; i++) begin
        regs_reg[i] <= regs_next[i];
      end
      reg_rdata  <= reg_rdata_next;
      reg_rvalid <= reg_rvalid_next;
      mem_req    <= mem_req_next;
    end
  end

  // buffer placement
  always_comb begin
    buf_size = buf_is_2m ? BUF_SIZE_2M : {1'b0, BUF_SIZE_512K};
    if (regs_reg[REG_OVL_START_SEL] == RESET_BYTE) begin
      ovl_addr_full = buf_size - CURSOR_BUF_BYTES;
    end else begin
      ovl_addr_full = buf_size
                    - (22'({14'h0000, regs_reg[REG_OVL_START_SEL]}) << OVL_SLOT_SHIFT);
    end
    hfb_full = 22'(({12'h000, panel_width} * {12'h000, panel_height}
               << (colour_panel ? HFB_COLOUR_FACTOR : 2'h0)) >> HFB_SHIFT);
  end

  assign ovl_start_addr = ovl_addr_full[20:0];
  assign hfb_size       = (dual_panel && hfb_enable) ? hfb_full[20:0] : 21'h000000;
  assign hfb_start_addr = 21'(buf_size - {1'b0, hfb_size});
  assign image_line_words = pair16(regs_reg[REG_LINE_WIDTH_HI], regs_reg[REG_LINE_WIDTH_LO]);
  assign scr1_start_word = {regs_reg[REG_SCR1_START_2][3:0], regs_reg[REG_SCR1_START_1],
                            regs_reg[REG_SCR1_START_0]};
  assign scr2_start_word = {regs_reg[REG_SCR2_START_2][3:0], regs_reg[REG_SCR2_START_1],
                            regs_reg[REG_SCR2_START_0]};
  assign scr1_pan = regs_reg[REG_PIXEL_PAN][3:0];
  assign scr2_pan = regs_reg[REG_PIXEL_PAN][7:4];
  assign last_line      = pair16(regs_reg[REG_LAST_LINE_HI], regs_reg[REG_LAST_LINE_LO]);
  assign screen2_active = {6'h00, line_count} > last_line;
  assign gray_mod_alt   = regs_reg[REG_GRAY_MOD_SEL] != RESET_BYTE;
  assign ovl_mode = dbom_ovl_mode_t'(regs_reg[REG_OVL_CTRL][OVL_MODE_MSB:OVL_MODE_LSB]);
  assign ovl_line_words = (ovl_mode == DBOM_OVL_INK) ? image_line_words + 16'h0001
                                                     : CURSOR_LINE_WORDS;
  assign cur_x = 10'(mask_bits(regs_reg[REG_CUR_X_LO], regs_reg[REG_CUR_X_HI]));
  assign cur_y = 10'(mask_bits(regs_reg[REG_CUR_Y_LO], regs_reg[REG_CUR_Y_HI]));
  assign col0 = pair16(regs_reg[REG_OVL_COL0_HI], regs_reg[REG_OVL_COL0_LO]);
  assign col1 = pair16(regs_reg[REG_OVL_COL1_HI], regs_reg[REG_OVL_COL1_LO]);

  // pixel composition
  always_comb begin
    if (direct_colour) begin
      back_colour = pixel_in.pixel;
    end else if (mono_mode) begin
      back_colour = expand_444(lut_green, lut_green, lut_green);
    end else begin
      back_colour = expand_444(lut_red, lut_green, lut_blue);
    end
    in_cursor = (pixel_in.x >= cur_x) && (pixel_in.x < 10'(cur_x + CURSOR_SIZE))
             && (pixel_in.y >= cur_y) && (pixel_in.y < 10'(cur_y + CURSOR_SIZE));
    pixel_next       = pixel_in;
    pixel_next.pixel = back_colour;
    if ((ovl_mode == DBOM_OVL_INK) || ((ovl_mode == DBOM_OVL_CURSOR) && in_cursor)) begin
      case (dbom_ovl_code_t'(pixel_in.code))
        DBOM_CODE_COL0: begin
          pixel_next.pixel = col0;
        end
        DBOM_CODE_COL1: begin
          pixel_next.pixel = col1;
        end
        DBOM_CODE_INV: begin
          pixel_next.pixel = ~back_colour;
        end
        default: begin
          pixel_next.pixel = back_colour;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pixel_out <= '0;
    end else if (clk_en) begin
      pixel_out <= pixel_next;
    end
  end

endmodule : dbom_mapper

// ---- hdl/dbom_pkg.sv ----
// Purpose: shared constants and types for the display buffer overlay mapper
// Assumes: byte-wide register port, 21-bit host byte address
// Notes:   register indices are the six-bit register select values
package dbom_pkg;

  localparam logic [5:0]  REG_LAST_LINE_LO   = 6'h0E;
  localparam logic [5:0]  REG_LAST_LINE_HI   = 6'h0F;
  localparam logic [5:0]  REG_SCR1_START_0   = 6'h10;
  localparam logic [5:0]  REG_SCR1_START_1   = 6'h11;
  localparam logic [5:0]  REG_SCR1_START_2   = 6'h12;
  localparam logic [5:0]  REG_SCR2_START_0   = 6'h13;
  localparam logic [5:0]  REG_SCR2_START_1   = 6'h14;
  localparam logic [5:0]  REG_SCR2_START_2   = 6'h15;
  localparam logic [5:0]  REG_LINE_WIDTH_LO  = 6'h16;
  localparam logic [5:0]  REG_LINE_WIDTH_HI  = 6'h17;
  localparam logic [5:0]  REG_PIXEL_PAN      = 6'h18;
  localparam logic [5:0]  REG_OVL_CTRL       = 6'h27;
  localparam logic [5:0]  REG_CUR_X_LO       = 6'h28;
  localparam logic [5:0]  REG_CUR_X_HI       = 6'h29;
  localparam logic [5:0]  REG_CUR_Y_LO       = 6'h2A;
  localparam logic [5:0]  REG_CUR_Y_HI       = 6'h2B;
  localparam logic [5:0]  REG_OVL_COL0_LO    = 6'h2C;
  localparam logic [5:0]  REG_OVL_COL0_HI    = 6'h2D;
  localparam logic [5:0]  REG_OVL_COL1_LO    = 6'h2E;
  localparam logic [5:0]  REG_OVL_COL1_HI    = 6'h2F;
  localparam logic [5:0]  REG_OVL_START_SEL  = 6'h30;
  localparam logic [5:0]  REG_GRAY_MOD_SEL   = 6'h31;

  localparam logic [7:0]  RESET_BYTE         = 8'h00;
  localparam int          OVL_MODE_MSB       = 7;
  localparam int          OVL_MODE_LSB       = 6;
  localparam int          CUR_HI_BITS        = 2;

  localparam logic [20:0] BUF_SIZE_512K      = 21'h080000;
  localparam logic [21:0] BUF_SIZE_2M        = 22'h200000;
  localparam logic [20:0] BUF_MASK_512K      = 21'h07FFFF;
  localparam logic [20:0] BUF_MASK_2M        = 21'h1FFFFF;
  localparam logic [21:0] CURSOR_BUF_BYTES   = 22'h000400;
  localparam int          OVL_SLOT_SHIFT     = 13;
  localparam logic [15:0] CURSOR_LINE_WORDS  = 16'h0008;
  localparam logic [9:0]  CURSOR_SIZE        = 10'h040;
  localparam int          HFB_SHIFT          = 4;
  localparam logic [1:0]  HFB_COLOUR_FACTOR  = 2'h2;

  typedef enum logic [1:0] {
    DBOM_OVL_OFF    = 2'b00,
    DBOM_OVL_CURSOR = 2'b01,
    DBOM_OVL_INK    = 2'b10,
    DBOM_OVL_RSVD   = 2'b11
  } dbom_ovl_mode_t;

  typedef enum logic [1:0] {
    DBOM_CODE_COL0  = 2'b00,
    DBOM_CODE_COL1  = 2'b01,
    DBOM_CODE_BACK  = 2'b10,
    DBOM_CODE_INV   = 2'b11
  } dbom_ovl_code_t;

  typedef struct packed {
    logic        cs_n;
    logic        mem_sel;
    logic        rd;
    logic        wr;
    logic [20:0] addr;
    logic [7:0]  wdata;
  } dbom_host_req_t;

  typedef struct packed {
    logic        mem_sel;
    logic        rd;
    logic        wr;
    logic [20:0] addr;
    logic [7:0]  wdata;
  } dbom_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [9:0]  x;
    logic [9:0]  y;
    logic [1:0]  code;
    logic [15:0] pixel;
  } dbom_pixel_t;

endpackage : dbom_pkg

// ---- sim/dbom_host.sv ----
// Purpose: host bus model driving the mapper request struct
// Assumes: each request held for one clock edge
// Notes:   released lines: cs_n high, rd and wr low, others show the inverse of the last value
`timescale 1ns/100ps
module dbom_host
  import dbom_pkg::*;
(
  input  wire logic     sys_clk,
  output dbom_host_req_t host_req
);
  initial host_req = '{1'b1, 1'b0, 1'b0, 1'b0, 21'h000000, 8'h00};
  task automatic acc(input logic cs_n, input logic m, input logic w,
                     input logic [20:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    host_req <= '{cs_n, m, !w, w, a, d};
    @(posedge sys_clk);
    host_req <= '{1'b1, !m, 1'b0, 1'b0, ~a, ~d};
  endtask : acc
endmodule : dbom_host

// ---- sim/dbom_mapper_sva.sv ----
// Purpose: port assertions for the overlay mapper
// Assumes: one clock, sync reset
// Notes:   bound into every mapper instance
`timescale 1ns/100ps
module dbom_mapper_sva
  import dbom_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           rst,
  input wire logic           clk_en,
  input wire dbom_host_req_t host_req,
  input wire logic           reg_rvalid,
  input wire dbom_mem_req_t  mem_req,
  input wire logic           buf_is_2m,
  input wire logic           dual_panel,
  input wire logic           hfb_enable,
  input wire logic           colour_panel,
  input wire logic           direct_colour,
  input wire logic [9:0]     panel_width,
  input wire logic [9:0]     panel_height,
  input wire dbom_pixel_t    pixel_in,
  input wire dbom_pixel_t    pixel_out,
  input wire logic [20:0]    ovl_start_addr,
  input wire logic [20:0]    hfb_start_addr,
  input wire logic [20:0]    hfb_size
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_acc;
  logic mem_acc;
  logic hfb_on;
  assign rd_acc  = clk_en && !host_req.cs_n && !host_req.mem_sel && host_req.rd;
  assign mem_acc = clk_en && !host_req.cs_n && host_req.mem_sel;
  assign hfb_on  = dual_panel && hfb_enable;
  a_read_pulse: assert property (rd_acc |=> reg_rvalid)
    else $error("read gave no data pulse");
  a_read_quiet: assert property (clk_en && !rd_acc |=> !reg_rvalid)
    else $error("data pulse without read");
  a_deselect_idle: assert property (clk_en && host_req.cs_n |=> mem_req == '0)
    else $error("memory request while deselected");
  a_mem_alias: assert property (mem_acc |=> mem_req.mem_sel &&
    mem_req.addr == ($past(host_req.addr) & ($past(buf_is_2m) ? BUF_MASK_2M : BUF_MASK_512K)))
    else $error("memory address not aliased");
  a_pix_back: assert property (clk_en && pixel_in.code == DBOM_CODE_BACK &&
    direct_colour |=> pixel_out.pixel == $past(pixel_in.pixel))
    else $error("background code changed pixel");
  a_pix_place: assert property (clk_en |=> pixel_out.x == $past(pixel_in.x) &&
    pixel_out.y == $past(pixel_in.y) && pixel_out.valid == $past(pixel_in.valid))
    else $error("pixel position lost");
  a_half_off: assert property (!hfb_on |-> hfb_size == 21'h000000)
    else $error("half-frame size while disabled");
  a_half_size: assert property (hfb_on |->
    hfb_size == ((21'(panel_width) * panel_height) >> (colour_panel ? 2 : 4)))
    else $error("half-frame size wrong");
  a_half_top: assert property (hfb_on |->
    hfb_start_addr + hfb_size == (buf_is_2m ? 21'h000000 : BUF_SIZE_512K))
    else $error("half-frame not at top");
  a_ovl_align: assert property (ovl_start_addr[9:0] == 10'h000)
    else $error("overlay start misaligned");
endmodule : dbom_mapper_sva

bind dbom_mapper dbom_mapper_sva i_sva (.*);

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for the overlay mapper
// Assumes: host model drives the request struct
// Notes:   direct mode background is the stored pixel
`timescale 1ns/100ps
module testbench
  import dbom_pkg::*;
;
  localparam logic [15:0] BG = 16'h1234;
  logic           sys_clk, rst, clk_en, buf_is_2m, dual_panel, hfb_enable, colour_panel;
  logic           mono_mode, direct_colour, reg_rvalid, screen2_active, gray_mod_alt;
  logic [3:0]     lut_red, lut_green, lut_blue, scr1_pan, scr2_pan;
  logic [7:0]     reg_rdata;
  logic [9:0]     panel_width, panel_height, line_count;
  logic [15:0]    ovl_line_words, image_line_words;
  logic [19:0]    scr1_start_word, scr2_start_word;
  logic [20:0]    ovl_start_addr, hfb_start_addr, hfb_size;
  dbom_host_req_t host_req;
  dbom_mem_req_t  mem_req;
  dbom_pixel_t    pixel_in, pixel_out;
  int             err_count, cmp_count;
  dbom_host   i_host (.*);
  dbom_mapper i_dut (.*);
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [20:0] e, input logic [20:0] s);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_host.acc(1'b0, 1'b0, 1'b1, 21'(a), d);
    #1;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    i_host.acc(1'b0, 1'b0, 1'b0, 21'(a), 8'h00);
    #1;
    chk("rvalid", 21'h1, 21'(reg_rvalid));
    chk("rdata", 21'(e), 21'(reg_rdata));
  endtask : rd
  task automatic px(input logic [9:0] x, input logic [9:0] y, input logic [1:0] c,
                    input logic [15:0] e);
    @(posedge sys_clk);
    pixel_in <= '{1'b1, x, y, c, BG};
    @(posedge sys_clk);
    #1;
    chk("pixel", 21'(e), 21'(pixel_out.pixel));
  endtask : px
  task automatic t_regs;
    logic [7:0] v [4] = '{8'h00, 8'hFF, 8'hFA, 8'h01};
    chk("ovl_rst", 21'h1FFC00, ovl_start_addr);
    rd(REG_GRAY_MOD_SEL, 8'h00);
    foreach (v[i]) begin
      wr(REG_GRAY_MOD_SEL, v[i]);
      chk("gray_alt", 21'(v[i] != 8'h00), 21'(gray_mod_alt));
      rd(REG_GRAY_MOD_SEL, v[i]);
    end
    i_host.acc(1'b1, 1'b0, 1'b1, 21'(REG_GRAY_MOD_SEL), 8'h55);
    rd(REG_GRAY_MOD_SEL, 8'h01);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(REG_GRAY_MOD_SEL, 8'h77);
    clk_en <= 1'b1;
    rd(REG_GRAY_MOD_SEL, 8'h01);
  endtask : t_regs
  task automatic t_ovl;
    logic [7:0]  n [5] = '{8'd0, 8'd1, 8'd255, 8'd0, 8'd1};
    logic [21:0] e;
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      buf_is_2m <= (i < 3);
      wr(REG_OVL_START_SEL, n[i]);
      e = ((i < 3) ? 22'h200000 : 22'h080000) -
          ((n[i] == 8'd0) ? 22'd1024 : 22'(n[i]) * 22'd8192);
      chk("ovl_start", e[20:0], ovl_start_addr);
    end
  endtask : t_ovl
  task automatic t_lines;
    wr(REG_LINE_WIDTH_LO, 8'h34);
    wr(REG_LINE_WIDTH_HI, 8'h12);
    chk("line_words", 21'h1234, 21'(image_line_words));
    wr(REG_OVL_CTRL, 8'h80);
    chk("ink_stride", 21'h1235, 21'(ovl_line_words));
    wr(REG_OVL_CTRL, 8'h40);
    chk("cur_stride", 21'h8, 21'(ovl_line_words));
    for (int i = 0; i < 2; i++) begin
      wr(6'(REG_SCR1_START_0 + 3 * i), 8'h56 + 8'(i));
      wr(6'(REG_SCR1_START_1 + 3 * i), 8'h34);
      wr(6'(REG_SCR1_START_2 + 3 * i), 8'hF2);
    end
    chk("scr1", 21'h23456, 21'(scr1_start_word));
    chk("scr2", 21'h23457, 21'(scr2_start_word));
    wr(REG_PIXEL_PAN, 8'hA5);
    chk("pan", 21'hA5, 21'({scr2_pan, scr1_pan}));
    wr(REG_LAST_LINE_LO, 8'h05);
    wr(REG_LAST_LINE_HI, 8'h01);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      line_count <= 10'h105 + 10'(i);
      #1;
      chk("screen2", 21'(i), 21'(screen2_active));
    end
  endtask : t_lines
  task automatic t_mem;
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      buf_is_2m <= 1'(i);
      i_host.acc(1'b0, 1'b1, 1'b1, 21'h1ABCDE, 8'h5A);
      #1;
      chk("maddr", i ? 21'h1ABCDE : 21'h02BCDE, mem_req.addr);
      chk("mdata", 21'h15A, 21'({mem_req.wr, mem_req.wdata}));
    end
  endtask : t_mem
  task automatic t_hfb;
    @(posedge sys_clk);
    {dual_panel, hfb_enable, colour_panel, buf_is_2m} <= 4'hE;
    {panel_width, panel_height} <= {10'd640, 10'd480};
    #1;
    chk("hfb_size", 21'h012C00, hfb_size);
    chk("hfb_start", 21'h06D400, hfb_start_addr);
    @(posedge sys_clk);
    {colour_panel, buf_is_2m} <= 2'b01;
    #1;
    chk("hfb_mono", 21'h004B00, hfb_size);
    chk("hfb_top", 21'h1FB500, hfb_start_addr);
  endtask : t_hfb
  task automatic t_pix;
    logic [7:0] v [8] = '{8'h00, 8'h01, 8'h05, 8'h00, 8'h00, 8'hF8, 8'hE0, 8'h07};
    foreach (v[i]) wr(6'(REG_CUR_X_LO + i), v[i]);
    px(10'h100, 10'h005, 2'b00, 16'hF800);
    px(10'h13F, 10'h044, 2'b01, 16'h07E0);
    px(10'h140, 10'h005, 2'b00, BG);
    px(10'h100, 10'h004, 2'b00, BG);
    px(10'h120, 10'h020, 2'b11, ~BG);
    px(10'h120, 10'h020, 2'b10, BG);
    for (int i = 0; i < 4; i++) wr(6'(REG_CUR_X_LO + i), 8'h00);
    wr(REG_OVL_CTRL, 8'h80);
    px(10'h3FF, 10'h3FF, 2'b01, 16'h07E0);
    wr(REG_OVL_CTRL, 8'hC0);
    px(10'h000, 10'h000, 2'b00, BG);
    wr(REG_OVL_CTRL, 8'h00);
    px(10'h000, 10'h000, 2'b01, BG);
    @(posedge sys_clk);
    {mono_mode, direct_colour} <= 2'b10;
    px(10'h000, 10'h000, 2'b10, 16'hAD55);
  endtask : t_pix
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    {rst, clk_en, buf_is_2m, dual_panel, hfb_enable, colour_panel, mono_mode} = 7'h70;
    direct_colour = 1'b1;
    {panel_width, panel_height, line_count} = 30'h0;
    {lut_red, lut_green, lut_blue} = 12'h1A5;
    pixel_in = '0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_ovl();
    t_lines();
    t_mem();
    t_hfb();
    t_pix();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
endmodule : testbench
